// ### logic/hfo_ctrl.sv
// High-frequency oscillator control, post-scaler and suspend logic
//
// Contract
// - After reset the internal high-frequency oscillator clocks the system.
// - Calibration field resets to the factory trim for the nominal frequency; here reset loads the fixed CAL_TRIM_RST value 7'h40.
// - Post-scaler divides by 1, 2, 4 or 8; divide by 8 after reset.
// - Writing one to the suspend bit halts the oscillator, enters suspend.
// - Suspended with oscillator as source, core and peripheral clocks stop.
// - Wake on port 0 match, port 1 match, comparator low, timer 3 overflow.
// - On wake, oscillator, core and peripherals resume, interrupt enabled or not.
// - Core continues with the instruction after the write that suspended it.
// - Seven-bit calibration: all zeros fastest, all ones slowest period.
// - Calibration bit 7 reads zero; writes to it are ignored.
// - Enable bit turns the oscillator off when clear, on when set; set at reset.
// - Ready flag reads one only while running at programmed frequency.
// - Divider select 00 = /8, 01 = /4, 10 = /2, 11 = /1.
// - Sync busy reads one up to three timer clocks after a non-timer wake.
// - Source select 00 routes the scaled oscillator to the system clock.
`timescale 1ns/100ps
`default_nettype none
module hfo_ctrl (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [1:0] system_clock_source_select,
	input wire logic port0_match,
	input wire logic port1_match,
	input wire logic cmp0_enable,
	input wire logic cmp0_out,
	input wire logic timer3_overflow,
	input wire logic wake_timer_clk,
	output logic [7:0] sfr_rdata_q,
	output logic hf_system_clock_tick,
	output logic core_clk_hold_q,
	output logic osc_run_q,
	output logic [6:0] osc_trim_q
);
	hfo_pkg::hfo_state_type state_q;
	logic hf_osc_enable_bit_q;
	logic [1:0] hf_post_divider_select_q;
	logic [6:0] hf_osc_calibration_q;
	logic wake_timer_sync_busy_q;
	logic [1:0] sync_ticks_q;
	logic [3:0] settle_q;
	logic [5:0] meta_q;
	logic [5:0] sync_q;
	logic tick_prev_q;
	logic wr_ctrl;
	logic wr_cal;
	logic suspended;
	logic ready;
	logic wake_any;
	logic wake_other;
	logic timer_tick;
	logic [7:0] ctrl_view;

	assign wr_ctrl = sfr_wr && sfr_addr == hfo_pkg::ADDR_CONTROL;
	assign wr_cal = sfr_wr && sfr_addr == hfo_pkg::ADDR_CALIBRATION;
	assign suspended = state_q == hfo_pkg::HFO_SUSPENDED;
	assign ready = state_q == hfo_pkg::HFO_RUNNING;

	// Wake sources and timer clock come from other domains; two flops each
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= 6'h00;
			sync_q <= 6'h00;
		end
		else
		begin
			meta_q <= {wake_timer_clk, port0_match, port1_match, cmp0_enable, cmp0_out, timer3_overflow};
			sync_q <= meta_q;
		end
	end

	// Comparator wakes only when enabled and its output is low
	// Enable and output are synced apart, so both should not change in one cycle
	assign wake_any = sync_q[4] || sync_q[3] || (sync_q[2] && !sync_q[1]) || sync_q[0];
	assign wake_other = sync_q[4] || sync_q[3] || (sync_q[2] && !sync_q[1]);
	assign timer_tick = sync_q[5] && !tick_prev_q;

	// Oscillator state; reset starts it running so the core has a clock at once
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= hfo_pkg::HFO_RUNNING;
			settle_q <= 4'h0;
		end
		else
		begin
			case (state_q)
				hfo_pkg::HFO_OFF:
				begin
					if (wr_ctrl && sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT])
					begin
						state_q <= hfo_pkg::HFO_SETTLING;
						settle_q <= 4'h0;
					end
				end
				hfo_pkg::HFO_SETTLING:
				begin
					if (wr_ctrl && !sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT])
						state_q <= hfo_pkg::HFO_OFF;
					else if (settle_q == 4'(hfo_pkg::OSC_SETTLE_CYC - 1))
						state_q <= hfo_pkg::HFO_RUNNING;
					else
						settle_q <= settle_q + 4'h1;
				end
				hfo_pkg::HFO_RUNNING:
				begin
					if (wr_ctrl && !sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT])
						state_q <= hfo_pkg::HFO_OFF;
					else if (wr_ctrl && sfr_wdata[hfo_pkg::CTRL_SUSPEND_BIT])
						state_q <= hfo_pkg::HFO_SUSPENDED;
				end
				hfo_pkg::HFO_SUSPENDED:
				begin
					// Interrupt enables play no part in waking
					// Clearing enable still wins, so ready never shows with enable clear
					if (wr_ctrl && !sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT])
						state_q <= hfo_pkg::HFO_OFF;
					else if (wake_any)
					begin
						state_q <= hfo_pkg::HFO_SETTLING;
						settle_q <= 4'h0;
					end
				end
				default:
					state_q <= hfo_pkg::HFO_OFF;
			endcase
		end
	end

	// Software-owned fields
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			hf_osc_enable_bit_q <= hfo_pkg::CTRL_ENABLE_RST;
			hf_post_divider_select_q <= hfo_pkg::CTRL_DIV_RST;
			hf_osc_calibration_q <= hfo_pkg::CAL_TRIM_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				hf_osc_enable_bit_q <= sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT];
				hf_post_divider_select_q <= sfr_wdata[hfo_pkg::CTRL_DIV_LSB +: 2];
			end
			// Bit 7 has no storage
			if (wr_cal)
				hf_osc_calibration_q <= sfr_wdata[hfo_pkg::CAL_WIDTH-1:0];
		end
	end

	// Wake timer is unsafe for a few of its own clocks after a non-timer wake
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wake_timer_sync_busy_q <= 1'b0;
			sync_ticks_q <= 2'h0;
			tick_prev_q <= 1'b0;
		end
		else
		begin
			tick_prev_q <= sync_q[5];
			if (suspended && wake_other)
			begin
				wake_timer_sync_busy_q <= 1'b1;
				sync_ticks_q <= 2'h0;
			end
			else if (wake_timer_sync_busy_q && timer_tick)
			begin
				if (sync_ticks_q == 2'(hfo_pkg::SYNC_TIMER_TICKS - 1))
					wake_timer_sync_busy_q <= 1'b0;
				sync_ticks_q <= sync_ticks_q + 2'h1;
			end
		end
	end

	// Core stays halted until the oscillator is back; no instruction is lost,
	// so execution picks up right after the suspending write
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			core_clk_hold_q <= 1'b0;
			osc_run_q <= 1'b1;
			osc_trim_q <= hfo_pkg::CAL_TRIM_RST;
		end
		else
		begin
			core_clk_hold_q <= !ready && system_clock_source_select == hfo_pkg::SRC_HF_OSC;
			osc_run_q <= state_q == hfo_pkg::HFO_SETTLING || ready;
			// Trim passed straight to the analogue cell: larger code, longer period
			osc_trim_q <= hf_osc_calibration_q;
		end
	end

	// Ticks only while running, so restart waits a full divided period
	hfo_postdiv u_postdiv (
		.mclk(mclk),
		.nrst(nrst),
		.run(ready),
		.div_sel(hf_post_divider_select_q),
		.tick_q(hf_system_clock_tick)
	);

	assign ctrl_view = {hf_osc_enable_bit_q, ready, suspended, wake_timer_sync_busy_q, 2'h0, hf_post_divider_select_q};

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			sfr_rdata_q <= 8'h00;
		else if (sfr_rd && sfr_addr == hfo_pkg::ADDR_CONTROL)
			sfr_rdata_q <= ctrl_view;
		else if (sfr_rd && sfr_addr == hfo_pkg::ADDR_CALIBRATION)
			sfr_rdata_q <= {1'b0, hf_osc_calibration_q};
		else
			sfr_rdata_q <= 8'h00;
	end

	localparam int RESUME_MAX = hfo_pkg::OSC_SETTLE_CYC + 1;

	sequence seq_suspend_write;
		wr_ctrl && sfr_wdata[hfo_pkg::CTRL_SUSPEND_BIT] && sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT] && ready;
	endsequence

	sequence seq_wake;
		suspended && wake_any;
	endsequence

	AST_CAL_BIT7_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr_rd && sfr_addr == hfo_pkg::ADDR_CALIBRATION) |=> !sfr_rdata_q[7])
		else $error("calibration bit 7 read as one");
	AST_CAL_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
		wr_cal |=> ##1 osc_trim_q == $past(sfr_wdata[6:0], 2))
		else $error("calibration write not passed to trim");
	AST_SUSPEND_ENTER: assert property (@(posedge mclk) disable iff (!nrst)
		seq_suspend_write |=> suspended ##1 !osc_run_q)
		else $error("suspend write did not halt oscillator");
	AST_CORE_HELD: assert property (@(posedge mclk) disable iff (!nrst)
		(suspended && system_clock_source_select == hfo_pkg::SRC_HF_OSC) |=> core_clk_hold_q)
		else $error("core clock not held while suspended");
	AST_NO_TICK_SUSPENDED: assert property (@(posedge mclk) disable iff (!nrst)
		suspended [*2] |-> !hf_system_clock_tick)
		else $error("system clock tick during suspend");
	AST_WAKE_CLEARS: assert property (@(posedge mclk) disable iff (!nrst)
		seq_wake |=> !suspended)
		else $error("suspend bit not cleared by wake");
	AST_RESUME: assert property (@(posedge mclk) disable iff (!nrst)
		(seq_wake ##1 !wr_ctrl [*1]) |-> ##[1:RESUME_MAX] (ready || wr_ctrl))
		else $error("oscillator did not resume after wake");
	AST_READY_ONLY_ENABLED: assert property (@(posedge mclk) disable iff (!nrst)
		ready |-> hf_osc_enable_bit_q && !suspended)
		else $error("ready flag set while not running");
	AST_DISABLE: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_ctrl && !sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT]) |=> state_q == hfo_pkg::HFO_OFF ##1 !osc_run_q)
		else $error("clearing enable did not stop oscillator");
	AST_SYNC_BUSY: assert property (@(posedge mclk) disable iff (!nrst)
		(suspended && wake_other) |=> wake_timer_sync_busy_q)
		else $error("sync busy not raised on non-timer wake");

	sequence seq_settle_dark;
		(!ready) [*8] ##1 (!ready) [*2];
	endsequence

	// Read-only control bits come from live state, not storage; unused bits 3:2 read zero
	AST_CTRL_READ: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr_rd && sfr_addr == hfo_pkg::ADDR_CONTROL) |=> sfr_rdata_q[hfo_pkg::CTRL_READY_BIT] == $past(ready) && sfr_rdata_q[3:2] == 2'h0)
		else $error("control read shows wrong ready or unused bits");
	AST_DIV_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
		wr_ctrl |=> hf_post_divider_select_q == $past(sfr_wdata[hfo_pkg::CTRL_DIV_LSB +: 2]))
		else $error("divider select not stored");
	AST_ENABLE_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
		wr_ctrl |=> hf_osc_enable_bit_q == $past(sfr_wdata[hfo_pkg::CTRL_ENABLE_BIT]))
		else $error("enable bit not stored");
	// A disabled comparator must not wake, whatever its output shows
	AST_NO_SPURIOUS_WAKE: assert property (@(posedge mclk) disable iff (!nrst)
		(suspended && !wr_ctrl && !sync_q[2] && !sync_q[4] && !sync_q[3] && !sync_q[0]) |=> suspended)
		else $error("left suspend with no wake source");
	AST_TIMER_WAKE_NO_BUSY: assert property (@(posedge mclk) disable iff (!nrst)
		(suspended && sync_q[0] && !wake_other && !wake_timer_sync_busy_q) |=> !wake_timer_sync_busy_q)
		else $error("sync busy raised by timer wake");
	// Restart waits out the whole settling count before ready
	AST_SETTLE_FULL: assert property (@(posedge mclk) disable iff (!nrst)
		seq_wake |=> seq_settle_dark)
		else $error("ready shown before settling ended");
	AST_OSC_RESTART: assert property (@(posedge mclk) disable iff (!nrst)
		seq_wake |=> ##1 osc_run_q)
		else $error("oscillator not restarted after wake");
	AST_HOLD_RELEASE: assert property (@(posedge mclk) disable iff (!nrst)
		(ready && system_clock_source_select == hfo_pkg::SRC_HF_OSC) |=> !core_clk_hold_q)
		else $error("core clock still held while running");
endmodule
`default_nettype wire

// ### logic/hfo_pkg.sv
// Shared constants and types for the high-frequency oscillator control block
`default_nettype none
package hfo_pkg;
	// Special-function register addresses
	localparam logic [7:0] ADDR_CONTROL = 8'hb2;
	localparam logic [7:0] ADDR_CALIBRATION = 8'hb3;
	// Control register field positions
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_READY_BIT = 6;
	localparam int CTRL_SUSPEND_BIT = 5;
	localparam int CTRL_SYNC_BIT = 4;
	localparam int CTRL_DIV_LSB = 0;
	localparam int CAL_WIDTH = 7;
	// Reset values
	localparam logic CTRL_ENABLE_RST = 1'b1;
	localparam logic [1:0] CTRL_DIV_RST = 2'h0;
	// Trim value arbitrary; the real one comes from factory programming
	localparam logic [6:0] CAL_TRIM_RST = 7'h40;
	// Source select value that routes the scaled oscillator to the system clock
	localparam logic [1:0] SRC_HF_OSC = 2'h0;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int OSC_SETTLE_NS = 1000;
	localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_TIMER_TICKS = 3;
	typedef enum logic [1:0] {
		HFO_OFF,
		HFO_SETTLING,
		HFO_RUNNING,
		HFO_SUSPENDED
	} hfo_state_type;
endpackage
`default_nettype wire

// ### logic/hfo_postdiv.sv
// Glitch-free post-scaler producing one clock-enable pulse per divided period
`timescale 1ns/100ps
`default_nettype none
module hfo_postdiv (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run,
	input wire logic [1:0] div_sel,
	output logic tick_q
);
	logic [2:0] cnt_q;
	logic [3:0] len_q;
	logic [3:0] len_new;

	// 00 -> 8, 01 -> 4, 10 -> 2, 11 -> 1
	assign len_new = 4'h8 >> div_sel;

	// Length only changes at a period boundary, so no short pulse is ever made
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 3'h0;
			len_q <= 4'h8;
			tick_q <= 1'b0;
		end
		else if (!run)
		begin
			cnt_q <= 3'h0;
			len_q <= len_new;
			tick_q <= 1'b0;
		end
		else if ({1'b0, cnt_q} == len_q - 4'h1)
		begin
			cnt_q <= 3'h0;
			len_q <= len_new;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 3'h1;
			tick_q <= 1'b0;
		end
	end

	AST_DIV8_SPACING: assert property (@(posedge mclk) disable iff (!nrst)
		(tick_q && len_q == 4'h8 && run) |=> !tick_q [*7])
		else $error("divide-by-8 tick spacing too short");
	AST_STOP_NO_TICK: assert property (@(posedge mclk) disable iff (!nrst)
		!run |=> !tick_q)
		else $error("tick produced while stopped");
endmodule
`default_nettype wire

// ### bench/hfo_wake_model.sv
// Wake-source model: port matches, comparator, timer overflow and wake-timer clock
`timescale 1ns/100ps
`default_nettype none
module hfo_wake_model (
	input wire logic [2:0] wake_sel,
	output logic port0_match,
	output logic port1_match,
	output logic cmp0_enable,
	output logic cmp0_out,
	output logic timer3_overflow,
	output logic wake_timer_clk
);
	// Code 5 drives the comparator low while disabled, which must not wake
	always_comb
	begin
		port0_match = wake_sel == 3'h1;
		port1_match = wake_sel == 3'h2;
		cmp0_enable = wake_sel != 3'h5;
		cmp0_out = !(wake_sel == 3'h3 || wake_sel == 3'h5);
		timer3_overflow = wake_sel == 3'h4;
	end
	// Slow free-running timer clock keeps the sync busy window wide enough to see
	initial
	begin
		wake_timer_clk = 1'b0;
		forever #1030 wake_timer_clk = !wake_timer_clk;
	end
endmodule
`default_nettype wire

// ### bench/hf_oscillator_suspend_control_tb_top.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module hf_oscillator_suspend_control_tb_top;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; int p;} hfo_row_type;
	logic mclk, nrst, sfr_wr, sfr_rd, p0, p1, ce, co, t3, wtc, tick, hold, run;
	logic [7:0] sfr_addr, sfr_wdata, rdata, d;
	logic [1:0] src;
	logic [6:0] trim;
	logic [2:0] wake_sel;
	int mismatches, cmp_count, cycles, n;
	hfo_row_type rows [8] = '{'{8'hb3, 8'h00, 8'h00, 0}, '{8'hb3, 8'hff, 8'h7f, 0}, '{8'hb3, 8'h40, 8'h40, 0},
		'{8'hb2, 8'h83, 8'hc3, 1}, '{8'hb2, 8'h82, 8'hc2, 2}, '{8'hb2, 8'h81, 8'hc1, 4},
		'{8'hb2, 8'h80, 8'hc0, 8}, '{8'h55, 8'hff, 8'h00, 0}};
	hfo_ctrl uut (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .system_clock_source_select(src), .port0_match(p0), .port1_match(p1),
		.cmp0_enable(ce), .cmp0_out(co), .timer3_overflow(t3), .wake_timer_clk(wtc), .sfr_rdata_q(rdata),
		.hf_system_clock_tick(tick), .core_clk_hold_q(hold), .osc_run_q(run), .osc_trim_q(trim));
	hfo_wake_model model (.wake_sel(wake_sel), .port0_match(p0), .port1_match(p1), .cmp0_enable(ce),
		.cmp0_out(co), .timer3_overflow(t3), .wake_timer_clk(wtc));
	task stop_test;
		$display("Compares %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge mclk);
		#10 {sfr_addr, sfr_wdata, sfr_wr} = {a, w, 1'b1};
		@(posedge mclk);
		#10 sfr_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge mclk);
		#10 {sfr_addr, sfr_rd} = {a, 1'b1};
		@(posedge mclk);
		#10 sfr_rd = 1'b0;
		r = rdata;
	endtask
	// Counts edges up to the next tick; bounded so a dead divider cannot hang
	task per(output int k);
		k = 0;
		do
		begin
			@(posedge mclk);
			#10 k++;
		end
		while (tick !== 1'b1 && k < 50);
	endtask
	task do_reset;
		@(posedge mclk);
		#10 nrst = 1'b0;
		repeat (10) @(posedge mclk);
		#10 nrst = 1'b1;
		per(n);
		chk(8'(n), 8'h08);
		rd(8'hb2, d);
		chk(d, 8'hc0);
		rd(8'hb3, d);
		chk(d, 8'h40);
		chk({1'b0, trim}, 8'h40);
	endtask
	task susp(input logic [2:0] code, input logic [1:0] s);
		src = s;
		wr(8'hb2, 8'ha0);
		repeat (2) @(posedge mclk);
		#10 chk(8'(run), 8'h00);
		chk(8'(hold), {7'h00, s == 2'h0});
		rd(8'hb2, d);
		chk(d, 8'ha0);
		wake_sel = 3'h5;
		repeat (16) @(posedge mclk);
		#10 chk(8'(run), 8'h00);
		wake_sel = code;
		repeat (16) @(posedge mclk);
		#10 wake_sel = 3'h0;
		chk(8'(hold), 8'h00);
		chk(8'(run), 8'h01);
		rd(8'hb2, d);
		chk(d, code == 3'h4 ? 8'hc0 : 8'hd0);
		per(n);
		per(n);
		chk(8'(n), 8'h08);
		repeat (80) @(posedge mclk);
		rd(8'hb2, d);
		chk(d, 8'hc0);
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = !mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			stop_test;
		end
	end
	initial
	begin
		{nrst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, src, wake_sel} = '0;
		do_reset;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			chk(d, rows[i].r);
			if (rows[i].a == 8'hb3)
				chk({1'b0, trim}, {1'b0, rows[i].r[6:0]});
			if (rows[i].p != 0)
			begin
				repeat (2) per(n);
				per(n);
				chk(8'(n), 8'(rows[i].p));
			end
		end
		wake_sel = 3'h1;
		repeat (20) @(posedge mclk);
		#10 wake_sel = 3'h0;
		rd(8'hb2, d);
		chk(d, 8'hc0);
		for (int c = 1; c < 5; c++)
			susp(c[2:0], 2'h0);
		susp(3'h2, 2'h1);
		src = 2'h0;
		wr(8'hb2, 8'h00);
		repeat (2) @(posedge mclk);
		#10 chk(8'(run), 8'h00);
		chk(8'(hold), 8'h01);
		rd(8'hb2, d);
		chk(d, 8'h00);
		wr(8'hb2, 8'h80);
		rd(8'hb2, d);
		chk(d, 8'h80);
		repeat (15) @(posedge mclk);
		rd(8'hb2, d);
		chk(d, 8'hc0);
		wr(8'hb3, 8'h11);
		wr(8'hb2, 8'h83);
		do_reset;
		stop_test;
	end
endmodule
`default_nettype wire
